// [shared/cmw_pkg.sv]
package cmw_pkg;
    localparam int DATA_W   = 16;
    localparam int WORD_W   = 17;
    localparam int HALF_W   = 9;
    localparam int PAR_POS  = 16;
    localparam logic [HALF_W-1:0] HALF_RST = 9'h000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

    typedef struct packed {
        logic addr_strobe;
        logic read_clear;
        logic sense_sample;
        logic write_latch_strobe;
        logic module_select;
    } cmw_strobe_s;
endpackage : cmw_pkg

// [verilog/cmw_parity.sv]
`timescale 1ns/10ps
`default_nettype none
module cmw_parity #(
    parameter int WIDTH = 16
) (
    // Data in
    input  wire logic [WIDTH-1:0] data_i,
    // Odd parity bit out
    output logic                  odd_bit_o
);
    // Ones when the data holds an even count of ones.
    assign odd_bit_o = ~(^data_i);
endmodule : cmw_parity
`default_nettype wire

// [verilog/cmw_digit_half.sv]
`timescale 1ns/10ps
`default_nettype none
module cmw_digit_half #(
    parameter int WIDTH = 9
) (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    // Control
    input  wire logic             clear_i,
    input  wire logic             sense_en_i,
    input  wire logic             load_i,
    // Data
    input  wire logic [WIDTH-1:0] write_i,
    input  wire logic [WIDTH-1:0] sense_i,
    output logic      [WIDTH-1:0] latch_o
);
    logic [WIDTH-1:0] latch_d;
    logic [WIDTH-1:0] latch_q;

    always_comb begin
        latch_d = latch_q;
        if (clear_i) begin
            latch_d = '0;
        end else if (load_i) begin
            latch_d = write_i;
        end else if (sense_en_i) begin
            // Sense can only set; a zero read leaves the latch unchanged.
            latch_d = latch_q | sense_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            latch_q <= '0;
        end else begin
            latch_q <= latch_d;
        end
    end

    assign latch_o = latch_q;
endmodule : cmw_digit_half
`default_nettype wire

// [verilog/cmw_datapath.sv]
`timescale 1ns/10ps
`default_nettype none
module cmw_datapath (
    // Clock and reset
    input  wire logic                          clock_i,
    input  wire logic                          rst_n_i,
    // Write sources
    input  wire logic [cmw_pkg::DATA_W-1:0]    info_reg_out_n_i,
    input  wire logic [cmw_pkg::DATA_W-1:0]    outer_bus_n_i,
    input  wire logic                          loader_write_select_i,
    // Module timing
    input  wire cmw_pkg::cmw_strobe_s          strobe_i,
    input  wire logic                          data_out_strobe_n_i,
    // Core stack
    input  wire logic [cmw_pkg::WORD_W-1:0]    plane_sense_in_i,
    output logic      [cmw_pkg::WORD_W-1:0]    plane_inhibit_out_o,
    // Processor read side
    input  wire logic                          opcode_fetch_read_i,
    input  wire logic                          memory_read_op_i,
    input  wire logic                          bus_load_instruction_i,
    output logic      [cmw_pkg::WORD_W-1:0]    read_return_line_o,
    output logic                               read_latch_enable_n_o,
    output logic                               read_word_select_o,
    output logic      [cmw_pkg::DATA_W-1:0]    outer_bus_o,
    output logic      [cmw_pkg::DATA_W-1:0]    opcode_word_o,
    output logic                               parity_error_flag_o,
    // Write lines to the module
    output logic      [cmw_pkg::DATA_W-1:0]    shared_write_data_o,
    output logic                               write_parity_bit_o
);
    localparam int H = cmw_pkg::HALF_W;

    logic [cmw_pkg::DATA_W-1:0] mux_data;
    logic                       par_bit;
    logic [2*H-1:0]             wr_word;
    logic [2*H-1:0]             sense_word;
    logic [2*H-1:0]             buf_word;
    logic [cmw_pkg::WORD_W-1:0] buf17;
    logic                       sel_load;
    logic                       sel_clear;
    logic                       sel_sense;
    logic                       read_cycle_d;
    logic                       read_cycle_q;
    logic                       regen_par;
    logic                       par_mismatch;
    logic [cmw_pkg::DATA_W-1:0] hold_d;
    logic [cmw_pkg::DATA_W-1:0] hold_q;
    logic [cmw_pkg::WORD_W-1:0] ret_d;
    logic [cmw_pkg::WORD_W-1:0] ret_q;
    logic                       perr_d;
    logic                       perr_q;
    logic                       rle_n;

    // Both sources arrive inverted, so either path inverts once more.
    always_comb begin
        if (loader_write_select_i) begin
            mux_data = ~outer_bus_n_i;
        end else begin
            mux_data = ~info_reg_out_n_i;
        end
    end

    cmw_parity #(.WIDTH(cmw_pkg::DATA_W)) u_gen (
        .data_i    (mux_data),
        .odd_bit_o (par_bit)
    );

    // During a read cycle the write strobe loads the buffer with itself,
    // which restores the destructively read word.
    assign wr_word    = read_cycle_q ? {1'b0, buf17} : {1'b0, par_bit, mux_data};
    assign sense_word = {1'b0, plane_sense_in_i};
    assign sel_load   = strobe_i.module_select & strobe_i.write_latch_strobe;
    assign sel_clear  = strobe_i.module_select & strobe_i.read_clear;
    assign sel_sense  = strobe_i.module_select & strobe_i.sense_sample;

    // Lower half carries bits 1 to 9, upper half 10 to 16, parity and a spare.
    cmw_digit_half #(.WIDTH(H)) u_lo (
        .clock_i    (clock_i),
        .rst_n_i    (rst_n_i),
        .clear_i    (sel_clear),
        .sense_en_i (sel_sense),
        .load_i     (sel_load),
        .write_i    (wr_word[H-1:0]),
        .sense_i    (sense_word[H-1:0]),
        .latch_o    (buf_word[H-1:0])
    );
    cmw_digit_half #(.WIDTH(H)) u_hi (
        .clock_i    (clock_i),
        .rst_n_i    (rst_n_i),
        .clear_i    (sel_clear),
        .sense_en_i (sel_sense),
        .load_i     (sel_load),
        .write_i    (wr_word[2*H-1:H]),
        .sense_i    (sense_word[2*H-1:H]),
        .latch_o    (buf_word[2*H-1:H])
    );

    assign buf17 = buf_word[cmw_pkg::WORD_W-1:0];
    assign plane_inhibit_out_o = buf17;

    // Read cycle mark: set by a read clear, dropped after the write strobe.
    always_comb begin
        read_cycle_d = read_cycle_q;
        if (sel_clear) begin
            read_cycle_d = 1'b1;
        end else if (sel_load) begin
            read_cycle_d = 1'b0;
        end
    end

    cmw_parity #(.WIDTH(cmw_pkg::DATA_W)) u_chk (
        .data_i    (read_return_line_o[cmw_pkg::DATA_W-1:0]),
        .odd_bit_o (regen_par)
    );
    assign par_mismatch = regen_par ^ read_return_line_o[cmw_pkg::PAR_POS];

    assign rle_n = ~(memory_read_op_i & ~opcode_fetch_read_i & ~data_out_strobe_n_i);

    always_comb begin
        ret_d  = ret_q;
        hold_d = hold_q;
        perr_d = perr_q;
        if (!data_out_strobe_n_i && strobe_i.module_select) begin
            ret_d = buf17;
        end
        if (!rle_n) begin
            hold_d = buf17[cmw_pkg::DATA_W-1:0];
        end
        if (!data_out_strobe_n_i) begin
            perr_d = 1'b0;
        end else if (par_mismatch) begin
            // Flag stays until the data out strobe next goes low, with or without module select.
            perr_d = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            read_cycle_q <= 1'b0;
            ret_q        <= 17'h00000;
            hold_q       <= cmw_pkg::DATA_RST;
            perr_q       <= 1'b0;
        end else begin
            read_cycle_q <= read_cycle_d;
            ret_q        <= ret_d;
            hold_q       <= hold_d;
            perr_q       <= perr_d;
        end
    end

    assign read_return_line_o    = ret_q;
    assign read_latch_enable_n_o = rle_n;
    assign read_word_select_o    = bus_load_instruction_i;
    assign outer_bus_o           = bus_load_instruction_i ? hold_q : cmw_pkg::DATA_RST;
    assign opcode_word_o         = ret_q[cmw_pkg::DATA_W-1:0];
    assign parity_error_flag_o   = perr_q;
    assign shared_write_data_o   = mux_data;
    assign write_parity_bit_o    = par_bit;

    a_parity_odd: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ^{write_parity_bit_o, shared_write_data_o}) else $error("write word not odd");
    a_load_captures: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (sel_load && !read_cycle_q) |=> buf17 == $past({par_bit, mux_data})) else $error("buffer missed write");
    a_sense_sets: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (sel_sense && !sel_clear && !sel_load) |=> ((buf17 & $past(plane_sense_in_i)) == $past(plane_sense_in_i)))
        else $error("sense did not set");
    a_clear_read: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        sel_clear |=> buf17 == 17'h00000) else $error("buffer not cleared");
    a_restore_word: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (sel_load && read_cycle_q && !sel_clear) |=> buf17 == $past(buf17)) else $error("restore lost word");
    a_return_drive: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (!data_out_strobe_n_i && strobe_i.module_select) |=> ret_q == $past(buf17)) else $error("return not driven");
    a_perr_flag: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (par_mismatch && data_out_strobe_n_i) |=> parity_error_flag_o) else $error("parity error missed");
    a_fetch_nolatch: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        opcode_fetch_read_i |-> read_latch_enable_n_o) else $error("fetch latched data");
    a_mux_select: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        loader_write_select_i |-> shared_write_data_o == ~outer_bus_n_i) else $error("loader not selected");
    a_inhibit_follow: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        plane_inhibit_out_o == buf17) else $error("inhibit mismatch");
endmodule : cmw_datapath
`default_nettype wire

// [test/cmw_core_stack.sv]
`timescale 1ns/10ps
`default_nettype none
module cmw_core_stack (
    // Timing
    input  wire logic        clock_i,
    input  wire logic        commit_i,
    input  wire logic        sense_en_i,
    input  wire logic        flip_i,
    // Planes
    input  wire logic [16:0] inhibit_i,
    output logic      [16:0] sense_o
);
    logic [16:0] word_q;
    always_ff @(posedge clock_i) begin
        if (commit_i) begin
            word_q <= inhibit_i;
        end
    end
    // Outside the sample window the planes show the inverse, so a stray sample is caught.
    assign sense_o = sense_en_i ? (word_q ^ {16'h0000, flip_i}) : ~word_q;
endmodule : cmw_core_stack
`default_nettype wire

// [test/cmw_datapath_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module cmw_datapath_bench;
    logic clock_i, rst_n_i, sel, dos_n, fetch, rd_op, bus_load_instruction, commit, flip;
    logic [15:0] info_n, outer_n, opw, obus, swd;
    logic [16:0] sense, inh, ret;
    logic rle_n, rws, perr, wpar;
    cmw_pkg::cmw_strobe_s stb;
    int bad_count, num_checks;
    logic [49:0] rows [5] = '{{16'hFFFF, 16'h0000, 1'b0, 17'h10000}, {16'hFFFE, 16'h0000, 1'b0, 17'h00001},
        {16'h1234, 16'h0F0F, 1'b1, 17'h1F0F0}, {16'h1234, 16'h7FFF, 1'b1, 17'h08000},
        {16'hA5C3, 16'hFFFF, 1'b0, 17'h15A3C}};
    cmw_datapath DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .info_reg_out_n_i(info_n), .outer_bus_n_i(outer_n),
        .loader_write_select_i(sel), .strobe_i(stb), .data_out_strobe_n_i(dos_n), .plane_sense_in_i(sense),
        .plane_inhibit_out_o(inh), .opcode_fetch_read_i(fetch), .memory_read_op_i(rd_op),
        .bus_load_instruction_i(bus_load_instruction), .read_return_line_o(ret), .read_latch_enable_n_o(rle_n),
        .read_word_select_o(rws), .outer_bus_o(obus), .opcode_word_o(opw), .parity_error_flag_o(perr),
        .shared_write_data_o(swd), .write_parity_bit_o(wpar));
    cmw_core_stack stack (.clock_i(clock_i), .commit_i(commit), .sense_en_i(stb.sense_sample), .flip_i(flip),
        .inhibit_i(inh), .sense_o(sense));
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic step();
        @(posedge clock_i);
        #5;
    endtask : step
    task automatic wr(input logic [15:0] i_n, input logic [15:0] o_n, input logic s, input logic [16:0] w);
        info_n = i_n;
        outer_n = o_n;
        sel = s;
        #1 check({wpar, swd}, w);
        stb.write_latch_strobe = 1'b1;
        step();
        stb.write_latch_strobe = 1'b0;
        check(inh, w);
    endtask : wr
    task automatic rd(input logic f, input logic [16:0] w, input logic err);
        stb.read_clear = 1'b1;
        step();
        stb.read_clear = 1'b0;
        stb.sense_sample = 1'b1;
        step();
        stb.sense_sample = 1'b0;
        dos_n = 1'b0;
        rd_op = 1'b1;
        fetch = f;
        #1 check(rle_n, f);
        step();
        dos_n = 1'b1;
        rd_op = 1'b0;
        stb.write_latch_strobe = 1'b1;
        check(ret, w);
        check(opw, w[15:0]);
        step();
        stb.write_latch_strobe = 1'b0;
        check(inh, w);
        check(perr, err);
    endtask : rd
    task automatic finish_test();
        if (bad_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    initial begin
        #(3000 * 50);
        bad_count++;
        finish_test();
    end
    initial begin
        {sel, dos_n, fetch, rd_op, bus_load_instruction, commit, flip} = 7'h02;
        {info_n, outer_n} = 32'h0000_0000;
        stb = '0;
        stb.module_select = 1'b1;
        rst_n_i = 1'b0;
        bad_count = 0;
        num_checks = 0;
        step();
        step();
        rst_n_i = 1'b1;
        check({perr, ret}, 18'h00000);
        // Each row is committed to the stack, then overwritten in the buffer before the read.
        foreach (rows[i]) begin
            wr(rows[i][49:34], rows[i][33:18], rows[i][17], rows[i][16:0]);
            commit = 1'b1;
            step();
            commit = 1'b0;
            wr(16'h0000, 16'h0000, 1'b0, 17'h1FFFF);
            rd(i[0], rows[i][16:0], 1'b0);
            bus_load_instruction = 1'b1;
            // A fetch leaves the holding latch alone, so odd rows still show the word of the row before.
            #1 check({rws, obus}, {1'b1, rows[i - i[0]][15:0]});
            bus_load_instruction = 1'b0;
        end
        flip = 1'b1;
        rd(1'b0, 17'h15A3D, 1'b1);
        flip = 1'b0;
        stb.module_select = 1'b0;
        stb.write_latch_strobe = 1'b1;
        step();
        stb.write_latch_strobe = 1'b0;
        stb.module_select = 1'b1;
        check(inh, 17'h15A3D);
        rst_n_i = 1'b0;
        step();
        rst_n_i = 1'b1;
        check({perr, inh}, 18'h00000);
        finish_test();
    end
endmodule : cmw_datapath_bench
`default_nettype wire
